// *** uart_banked_register_decode_test.sv ***
// self-checking bench for the banked register decode
// assumes the host model drives the strobe bus
`timescale 1ns/1ps
module uart_banked_register_decode_test;
	import ubr_pkg::*;
	logic        i_clock, i_rstn, i_wr, i_rd, o_tx_write, o_rx_read;
	logic [2:0]  i_addr, o_prescale;
	logic [1:0]  i_tx_ready, i_rx_ready;
	logic [7:0]  i_wdata, i_rx_data, o_rdata, o_tx_data, o_ext_feature, o_flow_threshold;
	logic [7:0]  o_fifo_trigger_level, o_int_enable, o_fifo_control, o_modem_control;
	logic [7:0]  o_line_control, d, lc;
	logic [15:0] o_baud_divisor;
	int          n_errors = 0;
	int          check_count = 0;
	// 100 ns clock
	initial begin
		i_clock = 1'b0;
		forever #50 i_clock = ~i_clock;
	end
	ubr_host u_host(.i_clock, .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd),
		.o_wdata(i_wdata));
	ubr_decode u_dut(.i_clock, .i_rstn, .i_addr, .i_wr, .i_rd, .i_wdata, .i_rx_data,
		.i_tx_ready, .i_rx_ready, .o_rdata, .o_tx_write, .o_rx_read, .o_tx_data,
		.o_baud_divisor, .o_prescale, .o_ext_feature, .o_flow_threshold,
		.o_fifo_trigger_level, .o_int_enable, .o_fifo_control, .o_modem_control,
		.o_line_control);
	// compare and count
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// divisor bank, then normal offset 0 leaves divisor alone
	task automatic t_divisor();
		u_host.rd(3'h3, lc);
		chk("lc", RST_LINE_CONTROL, lc);
		u_host.wr(3'h3, BANK_DIVISOR);
		u_host.wr(3'h0, 8'h5a);
		u_host.wr(3'h1, 8'ha5);
		chk("div lo", 8'h5a, o_baud_divisor[7:0]);
		chk("div hi", 8'ha5, o_baud_divisor[15:8]);
		u_host.wr(3'h3, lc);
		u_host.wr(3'h0, 8'h33);
		chk("tx", 8'h33, o_tx_data);
		chk("div kept", 8'h5a, o_baud_divisor[7:0]);
	endtask
	// flow characters and ext feature in the extended bank
	task automatic t_chars();
		u_host.wr(3'h3, BANK_EXTENDED);
		for (int a = 4; a < 8; a++) u_host.wr(a[2:0], 8'hc0 | a[7:0]);
		for (int a = 4; a < 8; a++) begin
			u_host.rd(a[2:0], d);
			chk("char", 8'hc0 | a[7:0], d);
		end
		u_host.wr(3'h2, 8'h0a);
		chk("ext", 8'h0a, o_ext_feature);
		chk("thr", 8'h00, o_flow_threshold);
	endtask
	// locked writes, enhanced bank, prescaler, ready status
	task automatic t_enhanced();
		u_host.wr(3'h3, 8'h00);
		u_host.wr(3'h4, 8'h44);
		chk("mcr lock", 8'h04, o_modem_control);
		u_host.wr(3'h6, 8'h21);
		chk("thr lock", 8'h00, o_flow_threshold);
		u_host.enh_open();
		u_host.wr(3'h4, 8'h44);
		u_host.rd(3'h4, d);
		chk("mcr", 8'h44, d);
		u_host.wr(3'h6, 8'h21);
		u_host.wr(3'h7, 8'h38);
		chk("thr", 8'h21, o_flow_threshold);
		chk("trig", 8'h38, o_fifo_trigger_level);
		u_host.wr(3'h4, 8'hc4);
		chk("pre4", {5'h0, PRESCALE_DIV4}, {5'h0, o_prescale});
		u_host.wr(3'h4, 8'h44);
		chk("pre1", {5'h0, PRESCALE_DIV1}, {5'h0, o_prescale});
		{i_tx_ready, i_rx_ready} = 4'h9;
		u_host.ready_rd(d);
		chk("rdy", 8'h12, d);
		{i_tx_ready, i_rx_ready} = 4'h6;
		u_host.ready_rd(d);
		chk("rdy", 8'h21, d);
		u_host.enh_close();
		chk("ext back", 8'h0a, o_ext_feature);
		u_host.wr(3'h6, 8'h99);
		chk("thr kept", 8'h21, o_flow_threshold);
	endtask
	// normal bank offsets 0 to 2
	task automatic t_normal();
		u_host.wr(3'h3, 8'h03);
		u_host.wr(3'h1, 8'h0f);
		u_host.wr(3'h2, 8'h01);
		i_rx_data = 8'h6b;
		u_host.rd(3'h0, d);
		chk("ie", 8'h0f, o_int_enable);
		chk("fc", 8'h01, o_fifo_control);
		chk("rx", 8'h6b, d);
	endtask
	// reset, then the scenarios
	initial begin
		{i_rstn, i_rx_data, i_tx_ready, i_rx_ready} = 13'h0;
		repeat (16) @(posedge i_clock);
		#1 i_rstn = 1'b1;
		chk("div rst", RST_DIVISOR, o_baud_divisor[7:0]);
		t_divisor();
		t_chars();
		t_enhanced();
		t_normal();
		print_verdict();
	end
	// watchdog far past the expected run
	initial begin
		#100000;
		n_errors++;
		print_verdict();
	end
endmodule

// *** ubr_decode.sv ***
// banked register file and offset decode for one uart channel
// assumes a synchronous host strobe interface; fifo flags come from the same clock
//
// Overview of operation
// - line control 0x80: offset 0 reaches baud divisor low byte.
// - line control 0x80: offset 1 reaches baud divisor high byte.
// - line control 0xbf: offset 6 first stop char, offset 4 first resume char.
// - line control 0xbf: offset 7 second stop char, offset 5 second resume char.
// - line control 0xbf: offset 2 reaches extended feature register.
// - extended feature bit 4 enables enhanced functions; host sets then restores it.
// - line control 0, enhanced on, modem bit 6: offset 6 is flow threshold.
// - same conditions: offset 7 writes fifo trigger level register; reads it only with modem bit 2 clear.
// - host masks modem control, sets 0x40, reads offset 7 ready status, restores.
// - enhanced on and modem bit 7 clear: prescaler divides by one.
// - enhanced on and modem bit 7 set: prescaler divides by four.
// - line control at offset 3 reads back what was written.
// - line control 0: offset 4 is modem control, reads back its value.
// - flow threshold writes accepted only with enhanced on and modem bit 6.
// - ready status read-only: tx flags bits 0-1, rx flags bits 4-5.
`timescale 1ns/1ps
module ubr_decode
	import ubr_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_rstn,
	input  wire logic [2:0] i_addr,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_wdata,
	input  wire logic [7:0] i_rx_data,
	input  wire logic [1:0] i_tx_ready,
	input  wire logic [1:0] i_rx_ready,
	output logic      [7:0] o_rdata,
	output logic            o_tx_write,
	output logic            o_rx_read,
	output logic      [7:0] o_tx_data,
	output logic     [15:0] o_baud_divisor,
	output logic      [2:0] o_prescale,
	output logic      [7:0] o_ext_feature,
	output logic      [7:0] o_flow_threshold,
	output logic      [7:0] o_fifo_trigger_level,
	output logic      [7:0] o_int_enable,
	output logic      [7:0] o_fifo_control,
	output logic      [7:0] o_modem_control,
	output logic      [7:0] o_line_control
);
	logic [7:0] line_control_q;
	logic [7:0] modem_control_q;
	logic [7:0] div_low_q;
	logic [7:0] div_high_q;
	logic [7:0] ext_feature_q;
	logic [7:0] resume1_q;
	logic [7:0] resume2_q;
	logic [7:0] stop1_q;
	logic [7:0] stop2_q;
	logic [7:0] flow_threshold_q;
	logic [7:0] trigger_level_q;
	logic [7:0] int_enable_q;
	logic [7:0] fifo_control_q;
	logic [7:0] tx_data_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] ready_status;
	logic       enhanced;
	logic       enh_window;
	ubr_bank_t  bank;
	logic       we_line_control;
	logic       we_modem_control;
	logic       we_div_low;
	logic       we_div_high;
	logic       we_ext_feature;
	logic       we_resume1;
	logic       we_resume2;
	logic       we_stop1;
	logic       we_stop2;
	logic       we_flow_threshold;
	logic       we_trigger_level;
	logic       we_tx_data;
	logic       we_int_enable;
	logic       we_fifo_control;

	// enhanced functions enable and bank selection
	assign enhanced = ext_feature_q[EXT_ENHANCE_BIT];
	assign enh_window = enhanced && modem_control_q[MODEM_TCR_BIT];
	always_comb begin
		if (line_control_q == BANK_DIVISOR) begin
			bank = BANK_DIV;
		end else if (line_control_q == BANK_EXTENDED) begin
			bank = BANK_EXT;
		end else if (line_control_q == BANK_ENHANCED && enh_window) begin
			bank = BANK_ENH;
		end else begin
			bank = BANK_NORMAL;
		end
	end

	// write enable decode, one strobe per register, at most one high
	always_comb begin
		we_line_control   = 1'b0;
		we_modem_control  = 1'b0;
		we_div_low        = 1'b0;
		we_div_high       = 1'b0;
		we_ext_feature    = 1'b0;
		we_resume1        = 1'b0;
		we_resume2        = 1'b0;
		we_stop1          = 1'b0;
		we_stop2          = 1'b0;
		we_flow_threshold = 1'b0;
		we_trigger_level  = 1'b0;
		we_tx_data        = 1'b0;
		we_int_enable     = 1'b0;
		we_fifo_control   = 1'b0;
		if (i_wr && i_addr == OFS_LINE_CONTROL) begin
			we_line_control = 1'b1;
		end else if (i_wr && bank == BANK_DIV) begin
			we_div_low  = i_addr == OFS_DIV_LOW;
			we_div_high = i_addr == OFS_DIV_HIGH;
		end else if (i_wr && bank == BANK_EXT) begin
			we_ext_feature = i_addr == OFS_EXT_FEATURE;
			we_resume1     = i_addr == OFS_MODEM_RESUME1;
			we_resume2     = i_addr == OFS_RESUME2;
			we_stop1       = i_addr == OFS_STOP1_THRESH;
			we_stop2       = i_addr == OFS_STOP2_TRIG;
		end else if (i_wr) begin
			// normal and enhanced banks share offsets 0 to 2 and 4
			we_tx_data        = i_addr == OFS_DIV_LOW;
			we_int_enable     = i_addr == OFS_DIV_HIGH;
			we_fifo_control   = i_addr == OFS_EXT_FEATURE;
			we_modem_control  = i_addr == OFS_MODEM_RESUME1;
			we_flow_threshold = bank == BANK_ENH && i_addr == OFS_STOP1_THRESH;
			we_trigger_level  = bank == BANK_ENH && i_addr == OFS_STOP2_TRIG;
		end
	end

	// fifo ready status, one tx and one rx flag per channel
	for (genvar ch = 0; ch < 2; ch++) begin : g_ready
		assign ready_status[ch]     = i_tx_ready[ch];
		assign ready_status[ch + 4] = i_rx_ready[ch];
	end
	// unused status bits always read zero
	assign ready_status[3:2] = 2'b00;
	assign ready_status[7:6] = 2'b00;

	// line control, always at offset 3
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			line_control_q <= RST_LINE_CONTROL;
		end else if (we_line_control) begin
			line_control_q <= i_wdata;
		end
	end

	// modem control; upper bits writable only with enhanced on
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			modem_control_q <= RST_ZERO;
		end else if (we_modem_control) begin
			if (enhanced) begin
				modem_control_q <= i_wdata;
			end else begin
				modem_control_q <= {modem_control_q[7:5], i_wdata[4:0]};
			end
		end
	end

	// baud divisor low latch
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			div_low_q <= RST_DIVISOR;
		end else if (we_div_low) begin
			div_low_q <= i_wdata;
		end
	end

	// baud divisor high latch
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			div_high_q <= RST_ZERO;
		end else if (we_div_high) begin
			div_high_q <= i_wdata;
		end
	end

	// extended bank: feature register and flow characters
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			ext_feature_q <= RST_ZERO;
			resume1_q     <= RST_ZERO;
			resume2_q     <= RST_ZERO;
			stop1_q       <= RST_ZERO;
			stop2_q       <= RST_ZERO;
		end else if (we_ext_feature) begin
			ext_feature_q <= i_wdata;
		end else if (we_resume1) begin
			resume1_q <= i_wdata;
		end else if (we_resume2) begin
			resume2_q <= i_wdata;
		end else if (we_stop1) begin
			stop1_q <= i_wdata;
		end else if (we_stop2) begin
			stop2_q <= i_wdata;
		end
	end

	// flow threshold, gated by enhanced and modem bit 6
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			flow_threshold_q <= RST_ZERO;
		end else if (we_flow_threshold) begin
			flow_threshold_q <= i_wdata;
		end
	end

	// trigger level, same gating as the threshold
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			trigger_level_q <= RST_ZERO;
		end else if (we_trigger_level) begin
			trigger_level_q <= i_wdata;
		end
	end

	// normal bank: transmit data, interrupt enable, fifo control
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			tx_data_q      <= RST_ZERO;
			int_enable_q   <= RST_ZERO;
			fifo_control_q <= RST_ZERO;
		end else if (we_tx_data) begin
			tx_data_q <= i_wdata;
		end else if (we_int_enable) begin
			int_enable_q <= enhanced ? i_wdata : {int_enable_q[7:4], i_wdata[3:0]};
		end else if (we_fifo_control) begin
			fifo_control_q <= enhanced ? i_wdata
				: {i_wdata[7:6], fifo_control_q[5:4], i_wdata[3:0]};
		end
	end

	// read data mux, one clock of latency
	always_comb begin
		rdata_d = RST_ZERO;
		if (i_addr == OFS_LINE_CONTROL) begin
			rdata_d = line_control_q;
		end else if (bank == BANK_DIV && i_addr == OFS_DIV_LOW) begin
			rdata_d = div_low_q;
		end else if (bank == BANK_DIV && i_addr == OFS_DIV_HIGH) begin
			rdata_d = div_high_q;
		end else if (bank == BANK_EXT && i_addr == OFS_EXT_FEATURE) begin
			rdata_d = ext_feature_q;
		end else if (bank == BANK_EXT && i_addr == OFS_MODEM_RESUME1) begin
			rdata_d = resume1_q;
		end else if (bank == BANK_EXT && i_addr == OFS_RESUME2) begin
			rdata_d = resume2_q;
		end else if (bank == BANK_EXT && i_addr == OFS_STOP1_THRESH) begin
			rdata_d = stop1_q;
		end else if (bank == BANK_EXT && i_addr == OFS_STOP2_TRIG) begin
			rdata_d = stop2_q;
		end else if (bank == BANK_ENH && i_addr == OFS_STOP1_THRESH) begin
			rdata_d = flow_threshold_q;
		end else if (i_addr == OFS_STOP2_TRIG
				&& modem_control_q[MODEM_TCR_BIT] && modem_control_q[MODEM_READY_EN_BIT]) begin
			rdata_d = ready_status;
		end else if (bank == BANK_ENH && i_addr == OFS_STOP2_TRIG) begin
			rdata_d = trigger_level_q;
		end else if (i_addr == OFS_MODEM_RESUME1) begin
			rdata_d = modem_control_q;
		end else if (i_addr == OFS_DIV_LOW) begin
			rdata_d = i_rx_data;
		end else if (i_addr == OFS_DIV_HIGH) begin
			rdata_d = int_enable_q;
		end
	end

	// registered read data
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			rdata_q <= RST_ZERO;
		end else if (i_rd) begin
			rdata_q <= rdata_d;
		end
	end

	// data strobes toward the serial core
	assign o_tx_write = i_wr && i_addr == OFS_DIV_LOW
		&& (bank == BANK_NORMAL || bank == BANK_ENH);
	assign o_rx_read = i_rd && i_addr == OFS_DIV_LOW
		&& (bank == BANK_NORMAL || bank == BANK_ENH);

	// prescaler select
	assign o_prescale = (enhanced && modem_control_q[MODEM_PRESCALE_BIT])
		? PRESCALE_DIV4
		: PRESCALE_DIV1;

	// data path copies
	assign o_rdata              = rdata_q;
	assign o_tx_data            = tx_data_q;

	// control register copies
	assign o_baud_divisor       = {div_high_q, div_low_q};
	assign o_ext_feature        = ext_feature_q;
	assign o_flow_threshold     = flow_threshold_q;
	assign o_fifo_trigger_level = trigger_level_q;
	assign o_int_enable         = int_enable_q;
	assign o_fifo_control       = fifo_control_q;
	assign o_modem_control      = modem_control_q;
	assign o_line_control       = line_control_q;
endmodule

// *** ubr_host.sv ***
// host model issuing strobed register accesses
// assumes the decode samples strobes on the rising edge
`timescale 1ns/1ps
module ubr_host (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_rdata,
	output logic      [2:0] o_addr,
	output logic            o_wr,
	output logic            o_rd,
	output logic      [7:0] o_wdata
);
	logic [7:0] lc_q, ef_q, mc_q;
	// idle bus at time zero
	initial {o_addr, o_wr, o_rd, o_wdata} = 13'h0;
	// one write; data lines show the inverse once released
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clock) #1 {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
		@(posedge i_clock) #1 {o_wdata, o_wr} = {~d, 1'b0};
	endtask
	// one read; answer taken after the strobe edge
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_clock) #1 {o_addr, o_rd} = {a, 1'b1};
		@(posedge i_clock) #1 o_rd = 1'b0;
		d = i_rdata;
	endtask
	// save line control and ext feature, enable enhanced functions
	task automatic enh_open();
		rd(3'h3, lc_q); wr(3'h3, 8'hbf); rd(3'h2, ef_q);
		wr(3'h2, ef_q | 8'h10); wr(3'h3, 8'h00);
	endtask
	// put both back
	task automatic enh_close();
		wr(3'h3, 8'hbf); wr(3'h2, ef_q); wr(3'h3, lc_q);
	endtask
	// ready status read, modem control saved and restored
	task automatic ready_rd(output logic [7:0] d);
		rd(3'h4, mc_q); wr(3'h4, (mc_q & 8'hef) | 8'h40); rd(3'h7, d); wr(3'h4, mc_q);
	endtask
endmodule

// *** ubr_pkg.sv ***
// package for the banked register decode of one uart channel
// assumes an 8-bit host bus with a 3-bit offset
package ubr_pkg;
	// register offsets
	localparam logic [2:0] OFS_DIV_LOW      = 3'h0;
	localparam logic [2:0] OFS_DIV_HIGH     = 3'h1;
	localparam logic [2:0] OFS_EXT_FEATURE  = 3'h2;
	localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
	localparam logic [2:0] OFS_MODEM_RESUME1 = 3'h4;
	localparam logic [2:0] OFS_RESUME2      = 3'h5;
	localparam logic [2:0] OFS_STOP1_THRESH = 3'h6;
	localparam logic [2:0] OFS_STOP2_TRIG   = 3'h7;
	// bank select values held in line_control
	localparam logic [7:0] BANK_DIVISOR     = 8'h80;
	localparam logic [7:0] BANK_EXTENDED    = 8'hbf;
	localparam logic [7:0] BANK_ENHANCED    = 8'h00;
	// field positions
	localparam int EXT_ENHANCE_BIT   = 4;
	localparam int MODEM_TCR_BIT     = 6;
	localparam int MODEM_PRESCALE_BIT = 7;
	localparam int MODEM_READY_EN_BIT = 2;
	// reset values
	localparam logic [7:0] RST_LINE_CONTROL = 8'h1d;
	localparam logic [7:0] RST_ZERO         = 8'h00;
	localparam logic [7:0] RST_DIVISOR      = 8'h01;
	// prescaler divide ratios
	localparam logic [2:0] PRESCALE_DIV1 = 3'h1;
	localparam logic [2:0] PRESCALE_DIV4 = 3'h4;
	// register window selection
	typedef enum logic [1:0] {
		BANK_NORMAL,
		BANK_DIV,
		BANK_EXT,
		BANK_ENH
	} ubr_bank_t;
endpackage

// *** ubr_properties.sv ***
// assertions on the banked decode ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module ubr_properties (
	input wire logic        i_clock, i_rstn, i_wr, i_rd,
	input wire logic        o_tx_write,
	input wire logic        o_rx_read,
	input wire logic [2:0]  i_addr, o_prescale,
	input wire logic [1:0]  i_tx_ready, i_rx_ready,
	input wire logic [7:0]  i_wdata, o_rdata, o_ext_feature, o_flow_threshold,
	input wire logic [7:0]  o_fifo_trigger_level, o_modem_control, o_line_control,
	input wire logic [15:0] o_baud_divisor
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	// write strobe with offset, bank qualifiers
	wire [3:0] wa = {i_wr, i_addr};
	wire [7:0] lc = o_line_control;
	wire [7:0] mc = o_modem_control;
	wire       enh = lc == 8'h00 && o_ext_feature[4] && mc[6];
	// last cycle's write data
	logic [7:0] wd_q;
	always_ff @(posedge i_clock) wd_q <= i_wdata;
	a_lc_store:
		assert property (wa == 4'hb |=> lc == wd_q) else $error("lc store");
	a_div_low:
		assert property (wa == 4'h8 && lc == 8'h80 |=> o_baud_divisor[7:0] == wd_q) else $error("dl");
	a_div_high:
		assert property (wa == 4'h9 && lc == 8'h80 |=> o_baud_divisor[15:8] == wd_q) else $error("dh");
	a_ext_store:
		assert property (wa == 4'ha && lc == 8'hbf |=> o_ext_feature == wd_q) else $error("ext");
	a_thr_refuse:
		assert property (wa == 4'he && !enh |=> $stable(o_flow_threshold)) else $error("thr lock");
	a_thr_store:
		assert property (wa == 4'he && enh |=> o_flow_threshold == wd_q) else $error("thr");
	a_trig_store:
		assert property (wa == 4'hf && enh |=> o_fifo_trigger_level == wd_q) else $error("trig");
	a_pre_four:
		assert property (o_ext_feature[4] && mc[7] |-> o_prescale == 3'h4) else $error("pre4");
	a_ready_read:
		assert property (i_rd && i_addr == 3'h7 && mc[6] && mc[2] && lc != 8'h80 && lc != 8'hbf
			|=> o_rdata == {2'h0, $past(i_rx_ready), 2'h0, $past(i_tx_ready)}) else $error("rdy");
	a_tx_strobe:
		assert property (o_tx_write == (wa == 4'h8 && lc != 8'h80 && lc != 8'hbf))
			else $error("tx strobe");
	a_rx_strobe:
		assert property (o_rx_read == (i_rd && i_addr == 3'h0 && lc != 8'h80 && lc != 8'hbf))
			else $error("rx strobe");
endmodule
bind ubr_decode ubr_properties u_prop(.i_clock, .i_rstn, .i_wr, .i_rd, .o_tx_write, .o_rx_read,
	.i_addr, .o_prescale,
	.i_tx_ready, .i_rx_ready, .i_wdata, .o_rdata, .o_ext_feature, .o_flow_threshold,
	.o_fifo_trigger_level, .o_modem_control, .o_line_control, .o_baud_divisor);
